// ### hdl/serd_read_engine.sv
// Functional notes
// RULE1: Read opens like write: START, slave address, direction bit one.
// RULE2: Current-address, random and sequential reads share one address phase.
// RULE3: Counter holds last accessed address plus one, reads and writes alike.
// RULE4: Counter past 8191 wraps to 0 and keeps supplying data.
// RULE5: Read address match: acknowledge, then send addressed byte MSB first.
// RULE6: Master ends single read with no acknowledge then STOP.
// RULE7: Random read starts with dummy write of address words only.
// RULE8: Repeated START with read address returns byte at loaded address.
// RULE9: Master acknowledging a data byte continues into sequential read.
// RULE10: Each master acknowledge yields one more byte from next address.
// RULE11: No master acknowledge ends transmission; master then sends STOP.
// RULE12: Counter increments across all address bits, whole array streamable.
// RULE13: Acknowledge only address 1010 plus matching strap bits.
// RULE14: Release data line in ninth clock; no acknowledge, wait for STOP.
// RULE15: No acknowledge of slave address while programming cycle runs.
// RULE16: Dummy write carries two acknowledged address words.
// RULE17: Byte address is 13 bits; top three bits of first word ignored.
// RULE18: START or STOP mid-byte aborts, floats data, restarts reception.
`timescale 1ns/1ps

module serd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

module serd_read_engine (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        link_clk_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic        select_strap_bit0_i,
    input  wire logic        select_strap_bit1_i,
    input  wire logic        select_strap_bit2_i,
    input  wire logic        write_busy_i,
    output logic             mem_rd_o,
    output logic [12:0]      mem_addr_o,
    input  wire logic [7:0]  mem_rdata_i
);
    // =========================================================
    // Link domain: pin sampling
    // =========================================================
    serd_pkg::serd_link_in_s raw, syn;
    logic                    fack_q;

    assign raw = {scl_i, sda_i, select_strap_bit2_i, select_strap_bit1_i,
                  select_strap_bit0_i, write_busy_i, fack_q};

    serd_sync #(.W($bits(serd_pkg::serd_link_in_s))) u_lsync (
        .clk_i   (link_clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (raw),
        .q_o     (syn)
    );

    logic scl_p_q;
    logic sda_p_q;
    logic fack_p_q;

    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_p_q  <= 1'b1;
            sda_p_q  <= 1'b1;
            fack_p_q <= 1'b0;
        end else begin
            scl_p_q  <= syn.scl;
            sda_p_q  <= syn.sda;
            fack_p_q <= syn.fetch_ack;
        end
    end

    wire scl_rise = syn.scl & ~scl_p_q;
    wire scl_fall = ~syn.scl & scl_p_q;
    wire start_ev = syn.scl & scl_p_q & sda_p_q & ~syn.sda;
    wire stop_ev  = syn.scl & scl_p_q & ~sda_p_q & syn.sda;

    // =========================================================
    // Link domain: protocol state
    // =========================================================
    serd_pkg::serd_state_e st_q, st_d;
    logic [3:0]  bit_q, bit_d;
    logic [7:0]  sh_q, sh_d;
    logic [7:0]  tx_q, tx_d;
    logic [12:0] cnt_q, cnt_d;
    logic [4:0]  hi_q, hi_d;
    logic [1:0]  wcnt_q, wcnt_d;
    logic        rd_q, rd_d;
    logic        mack_q, mack_d;
    logic        oe_q;
    logic        freq_q;
    logic [12:0] faddr_q;
    logic [7:0]  fbuf_q;
    logic        fvalid_q;
    logic [7:0]  fdat_q;

    wire byte_done = scl_fall & (bit_q == serd_pkg::BYTE_BITS);
    wire rx_state  = (st_q == serd_pkg::ST_DEV) | (st_q == serd_pkg::ST_WORD);
    // RULE13 address match
    wire dev_hit   = (sh_q[7:4] == serd_pkg::DEV_CODE)
                   & (sh_q[3:1] == syn.strap);
    // RULE15 busy refusal
    wire dev_ack   = dev_hit & ~syn.busy;
    // RULE9 master ack continues
    wire load      = scl_fall & ((st_q == serd_pkg::ST_ACKO & rd_q)
                   | (st_q == serd_pkg::ST_RACK & mack_q));
    // RULE4 wrap at top
    wire [12:0] cnt_inc = (cnt_q == serd_pkg::ADDR_LAST)
                        ? serd_pkg::ADDR_RST : cnt_q + serd_pkg::ADDR_ONE;
    wire [3:0]  bit_inc = bit_q + serd_pkg::BIT_ONE;

    always_comb begin
        st_d   = st_q;
        bit_d  = bit_q;
        sh_d   = sh_q;
        tx_d   = tx_q;
        cnt_d  = cnt_q;
        hi_d   = hi_q;
        wcnt_d = wcnt_q;
        rd_d   = rd_q;
        mack_d = mack_q;
        if (rx_state && scl_rise) begin
            sh_d  = {sh_q[6:0], syn.sda};
            bit_d = bit_inc;
        end
        // RULE3 counter tracks access
        if (load) begin
            tx_d  = fbuf_q;
            cnt_d = cnt_inc;
        end
        case (st_q)
            serd_pkg::ST_IDLE: begin
                st_d = serd_pkg::ST_IDLE;
            end
            serd_pkg::ST_DEV: begin
                // RULE1 direction bit
                if (byte_done) begin
                    st_d   = dev_ack ? serd_pkg::ST_ACKO : serd_pkg::ST_IDLE;
                    rd_d   = sh_q[0];
                    wcnt_d = serd_pkg::WORD_HI;
                end
            end
            serd_pkg::ST_WORD: begin
                // RULE7 dummy write words
                if (byte_done) begin
                    st_d = serd_pkg::ST_ACKO;
                    rd_d = 1'b0;
                    case (wcnt_q)
                        serd_pkg::WORD_HI: begin
                            // RULE17 top bits dropped
                            hi_d   = sh_q[serd_pkg::HI_W-1:0];
                            wcnt_d = serd_pkg::WORD_LO;
                        end
                        serd_pkg::WORD_LO: begin
                            // RULE8 load new address
                            cnt_d  = {hi_q, sh_q};
                            wcnt_d = serd_pkg::WORD_DATA;
                        end
                        default: begin
                            cnt_d = cnt_inc;
                        end
                    endcase
                end
            end
            serd_pkg::ST_ACKO: begin
                // RULE2 shared address phase
                if (scl_fall) begin
                    bit_d = serd_pkg::BIT_RST;
                    st_d  = rd_q ? serd_pkg::ST_TX : serd_pkg::ST_WORD;
                end
            end
            serd_pkg::ST_TX: begin
                // RULE5 MSB first
                if (scl_fall) begin
                    tx_d  = {tx_q[6:0], 1'b0};
                    bit_d = bit_inc;
                    if (bit_q == serd_pkg::LAST_TX) begin
                        st_d = serd_pkg::ST_RACK;
                    end
                end
            end
            serd_pkg::ST_RACK: begin
                // RULE14 sample master ack
                if (scl_rise) begin
                    mack_d = ~syn.sda;
                end
                // RULE11 stop on no ack
                if (scl_fall) begin
                    bit_d = serd_pkg::BIT_RST;
                    st_d  = mack_q ? serd_pkg::ST_TX : serd_pkg::ST_IDLE;
                end
            end
            default: begin
                st_d = serd_pkg::ST_IDLE;
            end
        endcase
        // RULE18 start or stop aborts
        if (start_ev) begin
            st_d  = serd_pkg::ST_DEV;
            bit_d = serd_pkg::BIT_RST;
        end else if (stop_ev) begin
            st_d = serd_pkg::ST_IDLE;
        end
    end

    // Drive low only for ack or a zero data bit
    wire oe_d = (st_d == serd_pkg::ST_ACKO)
              | ((st_d == serd_pkg::ST_TX) & ~tx_d[7]);

    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q   <= serd_pkg::ST_IDLE;
            bit_q  <= serd_pkg::BIT_RST;
            sh_q   <= serd_pkg::BYTE_RST;
            tx_q   <= serd_pkg::BYTE_RST;
            cnt_q  <= serd_pkg::ADDR_RST;
            hi_q   <= '0;
            wcnt_q <= serd_pkg::WORD_HI;
            rd_q   <= 1'b0;
            mack_q <= 1'b0;
            oe_q   <= 1'b0;
        end else begin
            st_q   <= st_d;
            bit_q  <= bit_d;
            sh_q   <= sh_d;
            tx_q   <= tx_d;
            cnt_q  <= cnt_d;
            hi_q   <= hi_d;
            wcnt_q <= wcnt_d;
            rd_q   <= rd_d;
            mack_q <= mack_d;
            oe_q   <= oe_d;
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = oe_q;

    // =========================================================
    // Prefetch of the byte at the counter
    // =========================================================
    // Fetching ahead hides the crossing latency inside the byte being sent
    wire fetch_busy = freq_q ^ fack_p_q;
    wire fetch_done = syn.fetch_ack ^ fack_p_q;
    wire need_fetch = ~fetch_busy & ~(fvalid_q & (faddr_q == cnt_q));

    // RULE12 full width prefetch
    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            freq_q   <= 1'b0;
            faddr_q  <= serd_pkg::ADDR_RST;
            fbuf_q   <= serd_pkg::BYTE_RST;
            fvalid_q <= 1'b0;
        end else if (fetch_done) begin
            fbuf_q   <= fdat_q;
            fvalid_q <= 1'b1;
        end else if (need_fetch) begin
            freq_q   <= ~freq_q;
            faddr_q  <= cnt_q;
            fvalid_q <= 1'b0;
        end
    end

    // =========================================================
    // Core domain: memory read port
    // =========================================================
    logic creq_s;
    logic creq_p_q;
    logic crd_q;
    logic crdv_q;

    serd_sync #(.W(1)) u_csync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (freq_q),
        .q_o     (creq_s)
    );

    wire new_req = creq_s ^ creq_p_q;

    // RULE10 one byte per request
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            creq_p_q   <= 1'b0;
            crd_q      <= 1'b0;
            crdv_q     <= 1'b0;
            mem_addr_o <= serd_pkg::ADDR_RST;
            fdat_q     <= serd_pkg::BYTE_RST;
            fack_q     <= 1'b0;
        end else begin
            creq_p_q <= creq_s;
            crd_q    <= new_req;
            crdv_q   <= crd_q;
            if (new_req) begin
                mem_addr_o <= faddr_q;
            end
            if (crdv_q) begin
                fdat_q <= mem_rdata_i;
                fack_q <= ~fack_q;
            end
        end
    end

    assign mem_rd_o = crd_q;

    // =========================================================
    // Checks
    // =========================================================
    default clocking cb @(posedge link_clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_nohit;
        (byte_done && st_q == serd_pkg::ST_DEV && !dev_hit)
            |=> st_q == serd_pkg::ST_IDLE && !sda_oe_o;
    endproperty
    a_nohit: assert property (p_nohit) // RULE13
        else $error("non-matching address acknowledged");

    property p_busy;
        (byte_done && st_q == serd_pkg::ST_DEV && syn.busy) |=> !sda_oe_o;
    endproperty
    a_busy: assert property (p_busy) // RULE15
        else $error("address acknowledged while busy");

    property p_ack;
        (byte_done && st_q == serd_pkg::ST_DEV && dev_ack)
            |=> st_q == serd_pkg::ST_ACKO && sda_oe_o;
    endproperty
    a_ack: assert property (p_ack) // RULE5
        else $error("matching address not acknowledged");

    property p_load;
        load |=> st_q == serd_pkg::ST_TX && tx_q == $past(fbuf_q)
                 && sda_oe_o == !tx_q[7];
    endproperty
    a_load: assert property (p_load) // RULE10
        else $error("data byte not loaded from prefetch");

    property p_inc;
        (load && cnt_q != serd_pkg::ADDR_LAST)
            |=> cnt_q == $past(cnt_q) + serd_pkg::ADDR_ONE;
    endproperty
    a_inc: assert property (p_inc) // RULE3
        else $error("counter did not advance by one");

    property p_wrap;
        (load && cnt_q == serd_pkg::ADDR_LAST)
            |=> cnt_q == serd_pkg::ADDR_RST;
    endproperty
    a_wrap: assert property (p_wrap) // RULE4
        else $error("counter did not wrap to zero");

    sequence s_nack_end;
        st_q == serd_pkg::ST_RACK && scl_fall && !mack_q;
    endsequence
    property p_nack;
        s_nack_end |=> st_q == serd_pkg::ST_IDLE && !sda_oe_o
                       ##1 !sda_oe_o;
    endproperty
    a_nack: assert property (p_nack) // RULE11
        else $error("transmission continued after no acknowledge");

    property p_rel;
        st_q == serd_pkg::ST_RACK |-> !sda_oe_o;
    endproperty
    a_rel: assert property (p_rel) // RULE14
        else $error("data line driven in acknowledge bit");

    property p_start;
        start_ev |=> st_q == serd_pkg::ST_DEV
                     && bit_q == serd_pkg::BIT_RST && !sda_oe_o;
    endproperty
    a_start: assert property (p_start) // RULE18
        else $error("start did not restart address reception");

    property p_addr;
        (byte_done && st_q == serd_pkg::ST_WORD
         && wcnt_q == serd_pkg::WORD_LO)
            |=> cnt_q == {$past(hi_q), $past(sh_q)};
    endproperty
    a_addr: assert property (p_addr) // RULE17
        else $error("byte address not loaded from words");

    sequence s_fetch;
        mem_rd_o ##2 (fack_q != $past(fack_q));
    endsequence
    property p_fetch;
        @(posedge clk_i) disable iff (!rst_b_i)
            new_req |=> s_fetch;
    endproperty
    a_fetch: assert property (p_fetch) // RULE10
        else $error("fetch not answered in three cycles");

endmodule

// ### hdl/serd_pkg.sv
package serd_pkg;

    // =========================================================
    // Array and addressing
    // =========================================================
    localparam int          ADDR_W    = 13;
    localparam int          HI_W      = 5;
    localparam logic [12:0] ADDR_LAST = 13'h1fff;
    localparam logic [12:0] ADDR_RST  = 13'h0000;
    localparam logic [12:0] ADDR_ONE  = 13'h0001;
    localparam logic [3:0]  DEV_CODE  = 4'ha;

    // =========================================================
    // Byte framing
    // =========================================================
    localparam logic [3:0]  BYTE_BITS = 4'h8;
    localparam logic [3:0]  LAST_TX   = 4'h7;
    localparam logic [3:0]  BIT_RST   = 4'h0;
    localparam logic [3:0]  BIT_ONE   = 4'h1;
    localparam logic [7:0]  BYTE_RST  = 8'h00;
    localparam logic [1:0]  WORD_HI   = 2'h0;
    localparam logic [1:0]  WORD_LO   = 2'h1;
    localparam logic [1:0]  WORD_DATA = 2'h2;

    // =========================================================
    // Types
    // =========================================================
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_DEV  = 6'h02,
        ST_WORD = 6'h04,
        ST_ACKO = 6'h08,
        ST_TX   = 6'h10,
        ST_RACK = 6'h20
    } serd_state_e;

    // Everything the link domain synchronizes from outside
    typedef struct packed {
        logic       scl;
        logic       sda;
        logic [2:0] strap;
        logic       busy;
        logic       fetch_ack;
    } serd_link_in_s;

endpackage

// ### verif/serd_bus_master.sv
`timescale 1ns/1ps

module serd_bus_master #(
    parameter int Q = 8
) (
    input  wire logic clk_i,
    input  wire logic sda_i,
    input  wire logic dev_oe_i,
    output logic      scl_o,
    output logic      sda_low_o
);

    // =========================================================
    // Bus idle: clock line stands high between frames
    // =========================================================
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // =========================================================
    // One clock period; data only moves while the clock is low
    // =========================================================
    task automatic clk_bit(input logic low, output logic seen,
                           output logic oe);
        wt(Q);
        sda_low_o = low;
        wt(Q);
        scl_o = 1'b1;
        wt(Q);
        seen = sda_i;
        oe   = dev_oe_i;
        wt(Q);
        scl_o = 1'b0;
    endtask

    task automatic start_c();
        wt(Q);
        sda_low_o = 1'b0;
        wt(Q);
        scl_o = 1'b1;
        wt(Q);
        sda_low_o = 1'b1;
        wt(Q);
        scl_o = 1'b0;
    endtask

    task automatic stop_c();
        wt(Q);
        sda_low_o = 1'b1;
        wt(Q);
        scl_o = 1'b1;
        wt(Q);
        sda_low_o = 1'b0;
        wt(Q);
    endtask

    // address and word bytes, MSB first
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        logic o;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(~b[i], s, o);
        end
        clk_bit(1'b0, s, o);
        ack = ~s;
    endtask

    // master ack continues, no ack ends
    task automatic rd_byte(input logic ack, output logic [7:0] b,
                           output logic oe9);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b0, s, oe9);
            b[i] = s;
        end
        clk_bit(ack, s, oe9);
    endtask

endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps

module tb_top;

    localparam int N_MEM = 8192;

    logic        clk_i;
    logic        rst_b_i;
    logic        link_clk_i;
    logic        write_busy_i;
    logic [7:0]  mem_rdata_i;
    logic [2:0]  strap;
    logic        scl_w;
    logic        m_low;
    wire         sda_w;
    logic        sda_o;
    logic        sda_oe_o;
    logic        mem_rd_o;
    logic [12:0] mem_addr_o;
    logic [7:0]  mem [N_MEM];
    logic        rd_dly;
    int          fail_count;
    int          n_compared;
    int          cnt;

    // Open-drain line with pull-up: low if either side pulls
    assign sda_w = ~m_low & ~(sda_oe_o & ~sda_o);

    serd_read_engine dut_u (
        .clk_i               (clk_i),
        .rst_b_i             (rst_b_i),
        .link_clk_i          (link_clk_i),
        .scl_i               (scl_w),
        .sda_i               (sda_w),
        .sda_o               (sda_o),
        .sda_oe_o            (sda_oe_o),
        .select_strap_bit0_i (strap[0]),
        .select_strap_bit1_i (strap[1]),
        .select_strap_bit2_i (strap[2]),
        .write_busy_i        (write_busy_i),
        .mem_rd_o            (mem_rd_o),
        .mem_addr_o          (mem_addr_o),
        .mem_rdata_i         (mem_rdata_i)
    );

    serd_bus_master pm_u (
        .clk_i     (clk_i),
        .sda_i     (sda_w),
        .dev_oe_i  (sda_oe_o),
        .scl_o     (scl_w),
        .sda_low_o (m_low)
    );

    // =========================================================
    // Clocks and memory array
    // =========================================================
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial begin
        link_clk_i = 1'b0;
        #3;
        forever #6 link_clk_i = ~link_clk_i;
    end

    // Data stands through the cycle after the strobe, garbage otherwise
    always @(negedge clk_i) begin
        rd_dly <= mem_rd_o;
        if (mem_rd_o === 1'b1) begin
            mem_rdata_i <= mem[mem_addr_o];
        end else if (rd_dly !== 1'b1) begin
            mem_rdata_i <= ~mem_rdata_i;
        end
    end

    // =========================================================
    // Checking and verdict
    // =========================================================
    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        fail_count++;
        give_verdict();
    end

    // =========================================================
    // Transactions against the reference counter
    // =========================================================
    function automatic logic [7:0] sla(input logic rd);
        return {4'ha, strap, rd};
    endfunction

    task automatic read_seq(input int n);
        logic [7:0] b;
        logic       oe9;
        for (int k = 0; k < n; k++) begin
            pm_u.rd_byte(k < n - 1, b, oe9);
            check("read byte", {8'h00, b}, {8'h00, mem[cnt]});
            check("ninth bit drive", {15'h0000, oe9}, 16'h0000);
            cnt = (cnt + 1) % N_MEM;
        end
    endtask

    task automatic cur_read(input int n);
        logic ack;
        pm_u.start_c();
        pm_u.wr_byte(sla(1'b1), ack);
        check("read address ack", {15'h0000, ack}, 16'h0001);
        read_seq(n);
        pm_u.wt(20);
        check("drive after no ack", {15'h0000, sda_oe_o}, 16'h0000);
        pm_u.stop_c();
    endtask

    task automatic rnd_read(input logic [7:0] w0, input logic [7:0] w1,
                            input int n);
        logic ack;
        pm_u.start_c();
        pm_u.wr_byte(sla(1'b0), ack);
        check("write address ack", {15'h0000, ack}, 16'h0001);
        pm_u.wr_byte(w0, ack);
        check("high word ack", {15'h0000, ack}, 16'h0001);
        pm_u.wr_byte(w1, ack);
        check("low word ack", {15'h0000, ack}, 16'h0001);
        cnt = int'({w0[4:0], w1});
        cur_read(n);
    endtask

    // Write path: one data byte advances the counter past the address
    task automatic wr_data(input logic [7:0] w0, input logic [7:0] w1);
        logic ack;
        pm_u.start_c();
        pm_u.wr_byte(sla(1'b0), ack);
        pm_u.wr_byte(w0, ack);
        pm_u.wr_byte(w1, ack);
        pm_u.wr_byte(8'($urandom()), ack);
        check("data byte ack", {15'h0000, ack}, 16'h0001);
        pm_u.stop_c();
        cnt = (int'({w0[4:0], w1}) + 1) % N_MEM;
    endtask

    task automatic nak(input logic [7:0] a);
        logic ack;
        pm_u.start_c();
        pm_u.wr_byte(a, ack);
        check("refused address", {15'h0000, ack}, 16'h0000);
        pm_u.stop_c();
    endtask

    task automatic part_addr(input int nb);
        logic s;
        logic o;
        logic [7:0] a;
        a = sla(1'b1);
        pm_u.start_c();
        for (int i = 7; i > 7 - nb; i--) begin
            pm_u.clk_bit(~a[i], s, o);
        end
    endtask

    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        void'($urandom(65789));
        rst_b_i      = 1'b0;
        write_busy_i = 1'b0;
        mem_rdata_i  = 8'h00;
        fail_count   = 0;
        n_compared   = 0;
        cnt          = 0;
        strap        = 3'($urandom());
        foreach (mem[i]) begin
            mem[i] = 8'($urandom());
        end
        repeat (20) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (20) @(negedge clk_i);
        cur_read(1);
        write_busy_i = 1'b1;
        nak(sla(1'b1));
        write_busy_i = 1'b0;
        for (int j = 0; j < 3; j++) begin
            nak({4'ha, strap ^ 3'(1 << j), 1'b1});
        end
        nak({4'hb, strap, 1'b1});
        rnd_read(8'hff, 8'hfe, 4);
        cur_read(2);
        wr_data(8'hff, 8'hff);
        cur_read(1);
        part_addr(4);
        cur_read(1);
        part_addr(3);
        pm_u.stop_c();
        cur_read(1);
        for (int j = 0; j < 3; j++) begin
            rnd_read(8'($urandom()), 8'($urandom()), 2);
        end
        give_verdict();
    end

endmodule
